// file: hdl/pll_counter_network.sv
// counter network around a digital loop: prescale, feedback, seven output dividers
//
// Summary of operation
// - output rate ref times M over N*C
// - prescale and feedback divide 1 through 512
// - prescale divider divides frequency, no duty control
// - seven independent output dividers per loop
// - output dividers divide 1 to 512
// - high and low counts each 1 to 256
// - divide ratio equals high plus low count
// - cascaded dividers clock from previous divider
// - cascading fixed at build, not reprogrammable
// - duty step is 100% over divide value
// - any divider that is not cascaded may count any of eight taps
// - fine phase step is one eighth period
// - start delay of initial count minus one
// - runtime phase change only moves tap, unlimited
// - each tap step takes one step clock
// - no spread spectrum generation or detection
// - feedback divider drives out as feedback output
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pll_counter_network #(
  // cascade selection fixed in the configuration image; bit i chains output i from i-1
  parameter logic [6:0] CASCADE_MASK = 7'h00
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // reference and feedback pins
  input wire logic ref_in,
  input wire logic feedback_in,
  output logic feedback_output,
  // dynamic phase stepping pins
  input wire logic phase_step_clock,
  input wire logic phase_step_up,
  input wire logic [2:0] phase_step_sel,
  // divided clocks to global_clock_net, regional nets or pins
  output logic [6:0] clk_out,
  output logic locked
);

  typedef struct packed {
    logic run;
    logic ext_fb;
    logic [8:0] n_m1;
    logic [8:0] m_m1;
    logic [2:0] m_tap;
    pll_net_pkg::out_cfg_t [6:0] out_cfg;
    logic [15:0] acc;
    logic [2:0] prev_tap;
    logic [12:0] inc;
    logic [8:0] pre_cnt;
    logic [8:0] fb_cnt;
    logic [1:0] fb_seen;
    logic [1:0] in_s1;
    logic [1:0] in_s2;
    logic [1:0] in_s3;
    logic [1:0] in_lvl;
    logic [4:0] step_s1;
    logic [4:0] step_s2;
    logic [4:0] step_s3;
    logic step_lvl;
    logic fb_out;
    logic locked;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } core_state_t;

  // reset image: output dividers at divide-by-two, prescale and feedback at divide-by-one, tap zero, no delay
  function automatic core_state_t core_rst();
    core_state_t r;
    r = '0;
    r.n_m1 = pll_net_pkg::DIV_M1_RST;
    r.m_m1 = pll_net_pkg::DIV_M1_RST;
    r.m_tap = pll_net_pkg::TAP_RST;
    r.inc = pll_net_pkg::INC_RST;
    for (int i = 0; i < 7; i++) begin
      r.out_cfg[i].high_m1 = pll_net_pkg::HALF_M1_RST;
      r.out_cfg[i].low_m1 = pll_net_pkg::HALF_M1_RST;
      r.out_cfg[i].init_cnt = pll_net_pkg::INIT_RST;
      r.out_cfg[i].tap = pll_net_pkg::TAP_RST;
      r.out_cfg[i].bypass = 1'b0;
    end
    return r;
  endfunction

  core_state_t st;
  core_state_t next_st;
  logic [7:0] tap_tick;
  logic [7:0] tap_level;
  logic [6:0] div_out;
  logic [6:0] div_rise;
  logic pre_evt;
  logic step_evt;
  logic [2:0] tap_now;

  // ******************************************************************
  // eight vco phase taps
  // ******************************************************************
  // one vco period is one wrap of the accumulator top bits, so each tap
  // lags the previous by one eighth period; no modulation is ever added
  assign tap_now = st.acc[15:13];
  for (genvar t = 0; t < 8; t++) begin : g_tap
    logic [2:0] tap_dist;
    assign tap_dist = tap_now - 3'(t);
    assign tap_tick[t] = (tap_now != st.prev_tap) && (tap_now == 3'(t));
    assign tap_level[t] = !tap_dist[2];
  end

  // ******************************************************************
  // output dividers
  // ******************************************************************
  for (genvar i = 0; i < 7; i++) begin : g_out
    logic tick_src;
    if (i > 0 && CASCADE_MASK[i]) begin : g_casc
      assign tick_src = div_rise[i-1]; // chained divider counts previous output
    end else begin : g_tap_src
      assign tick_src = tap_tick[st.out_cfg[i].tap];
    end
    out_divider u_div (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .ce(ce),
      .hold(!st.run),
      .tick(tick_src),
      .vco_level(tap_level[st.out_cfg[i].tap]),
      .bypass(st.out_cfg[i].bypass),
      .high_m1(st.out_cfg[i].high_m1),
      .low_m1(st.out_cfg[i].low_m1),
      .init_cnt(st.out_cfg[i].init_cnt),
      .div_out(div_out[i]),
      .div_rise(div_rise[i])
    );
  end

  // ******************************************************************
  // loop, phase stepping and register access
  // ******************************************************************
  always_comb begin
    logic [1:0] in_rise;
    logic fb_evt;
    logic loop_evt;
    logic [1:0] seen;
    logic [2:0] sel;
    logic [3:0] widx;
    logic [11:0] rel;
    in_rise = 2'b00;
    fb_evt = 1'b0;
    loop_evt = 1'b0;
    seen = 2'b00;
    sel = 3'h0;
    widx = 4'h0;
    rel = 12'h000;
    pre_evt = 1'b0;
    step_evt = 1'b0;
    next_st = st;

    // nco stands in for the vco; its rate is trimmed by the loop below
    next_st.acc = st.acc + 16'(st.inc); // fixed step, no spread
    next_st.prev_tap = tap_now;

    // pin synchronisers: an edge counts once stages two and three agree
    next_st.in_s1 = {feedback_in, ref_in};
    next_st.in_s2 = st.in_s1;
    next_st.in_s3 = st.in_s2;
    for (int k = 0; k < 2; k++) begin
      if (st.in_s2[k] == st.in_s3[k]) begin
        next_st.in_lvl[k] = st.in_s3[k];
        in_rise[k] = st.in_s3[k] && !st.in_lvl[k];
      end
    end
    next_st.step_s1 = {phase_step_clock, phase_step_up, phase_step_sel};
    next_st.step_s2 = st.step_s1;
    next_st.step_s3 = st.step_s2;
    if (st.step_s2[4] == st.step_s3[4]) begin
      next_st.step_lvl = st.step_s3[4];
      step_evt = st.step_s3[4] && !st.step_lvl;
    end

    // prescale: a plain event every N reference edges, no duty shaping
    if (in_rise[0]) begin
      if (st.pre_cnt >= st.n_m1) begin
        next_st.pre_cnt = 9'h000;
        pre_evt = 1'b1;
      end else begin
        next_st.pre_cnt = st.pre_cnt + 9'h001;
      end
    end

    // feedback divider counts its own tap; level is near 50% for the pin
    if (tap_tick[st.m_tap]) begin
      if (st.fb_cnt >= st.m_m1) begin
        next_st.fb_cnt = 9'h000;
        fb_evt = 1'b1;
      end else begin
        next_st.fb_cnt = st.fb_cnt + 9'h001;
      end
    end
    next_st.fb_out = (st.m_m1 == 9'h000) ? tap_level[st.m_tap] : (next_st.fb_cnt <= (st.m_m1 >> 1));

    // in external mode the loop closes through the returning pin
    loop_evt = st.ext_fb ? in_rise[1] : fb_evt;
    seen = (loop_evt && st.fb_seen != 2'h3) ? st.fb_seen + 2'h1 : st.fb_seen;
    next_st.fb_seen = seen;
    if (pre_evt) begin
      // a feedback event in the closing cycle still counts in this compare; the clear of fb_seen wins
      next_st.fb_seen = 2'h0;
      next_st.locked = (seen == 2'h1);
      if (seen == 2'h0 && st.inc != pll_net_pkg::INC_MAX) begin
        next_st.inc = st.inc + 13'h0001;
      end else if (seen >= 2'h2 && st.inc > 13'h0001) begin
        next_st.inc = st.inc - 13'h0001;
      end
    end

    // apb: one wait state, data and error latched with pready
    next_st.pready = psel && penable && !st.pready;
    if (psel && penable && !st.pready) begin
      next_st.prdata = 32'h0000_0000;
      next_st.pslverr = 1'b0;
      rel = paddr - pll_net_pkg::OUT_BASE_OFS;
      if (paddr == pll_net_pkg::CTRL_OFS) begin
        next_st.prdata[pll_net_pkg::CTRL_RUN_BIT] = st.run;
        next_st.prdata[pll_net_pkg::CTRL_EXTFB_BIT] = st.ext_fb;
      end else if (paddr == pll_net_pkg::STATUS_OFS) begin
        next_st.prdata[pll_net_pkg::STAT_LOCK_BIT] = st.locked;
        next_st.prdata[pll_net_pkg::STAT_CASC_LSB +: 7] = CASCADE_MASK;
        next_st.prdata[pll_net_pkg::STAT_INC_LSB +: pll_net_pkg::INC_W] = st.inc;
      end else if (paddr == pll_net_pkg::PRESCALE_OFS) begin
        next_st.prdata[pll_net_pkg::DIV_LSB +: pll_net_pkg::CNT_W] = st.n_m1;
      end else if (paddr == pll_net_pkg::FEEDBACK_OFS) begin
        next_st.prdata[pll_net_pkg::DIV_LSB +: pll_net_pkg::CNT_W] = st.m_m1;
        next_st.prdata[pll_net_pkg::FB_TAP_LSB +: 3] = st.m_tap;
      end else if (paddr >= pll_net_pkg::OUT_BASE_OFS && rel[1:0] == 2'b00 && rel[11:2] < 10'd7) begin
        next_st.prdata[28:0] = st.out_cfg[rel[4:2]];
      end else begin
        next_st.pslverr = 1'b1;
      end
    end
    if (psel && penable && st.pready && pwrite && !st.pslverr) begin
      rel = paddr - pll_net_pkg::OUT_BASE_OFS;
      widx = {1'b0, rel[4:2]};
      if (paddr == pll_net_pkg::CTRL_OFS) begin
        next_st.run = pwdata[pll_net_pkg::CTRL_RUN_BIT];
        next_st.ext_fb = pwdata[pll_net_pkg::CTRL_EXTFB_BIT];
      end else if (paddr == pll_net_pkg::PRESCALE_OFS) begin
        next_st.n_m1 = pwdata[pll_net_pkg::DIV_LSB +: pll_net_pkg::CNT_W];
      end else if (paddr == pll_net_pkg::FEEDBACK_OFS) begin
        next_st.m_m1 = pwdata[pll_net_pkg::DIV_LSB +: pll_net_pkg::CNT_W];
        next_st.m_tap = pwdata[pll_net_pkg::FB_TAP_LSB +: 3];
      end else if (paddr >= pll_net_pkg::OUT_BASE_OFS && widx < 4'd7) begin
        // duty resolution is one vco period over the divide value
        next_st.out_cfg[widx[2:0]].high_m1 = pwdata[pll_net_pkg::OUT_HIGH_LSB +: pll_net_pkg::HALF_W];
        next_st.out_cfg[widx[2:0]].low_m1 = pwdata[pll_net_pkg::OUT_LOW_LSB +: pll_net_pkg::HALF_W];
        next_st.out_cfg[widx[2:0]].init_cnt = pwdata[pll_net_pkg::OUT_INIT_LSB +: pll_net_pkg::CNT_W];
        next_st.out_cfg[widx[2:0]].tap = pwdata[pll_net_pkg::OUT_TAP_LSB +: 3];
        next_st.out_cfg[widx[2:0]].bypass = pwdata[pll_net_pkg::OUT_BYP_BIT];
      end
    end

    // a phase step only moves a tap; it wins over a same-cycle write
    if (step_evt) begin
      sel = st.step_s3[2:0];
      if (sel == pll_net_pkg::STEP_SEL_FB) begin
        next_st.m_tap = st.step_s3[3] ? st.m_tap + 3'h1 : st.m_tap - 3'h1;
      end else begin
        next_st.out_cfg[sel].tap = st.step_s3[3] ? st.out_cfg[sel].tap + 3'h1 : st.out_cfg[sel].tap - 3'h1;
      end
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st <= core_rst();
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign feedback_output = st.fb_out;
  assign locked = st.locked;
  assign clk_out = div_out;

  // ******************************************************************
  // checks
  // ******************************************************************
  a_tap_single: assert property (@(posedge ref_clk) disable iff (!rstn) $onehot0(tap_tick))
    else $error("more than one vco tap fired at once");

  a_prescale_wrap: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && in_rise_chk() && st.pre_cnt >= st.n_m1) |=> (st.pre_cnt == 9'h000))
    else $error("prescale counter did not wrap at its setting");

  a_fb_wrap: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && tap_tick[st.m_tap] && st.fb_cnt >= st.m_m1) |=> (st.fb_cnt == 9'h000))
    else $error("feedback counter did not wrap at its setting");

  a_inc_floor: assert property (@(posedge ref_clk) disable iff (!rstn) st.inc != 13'h0000)
    else $error("loop rate fell to zero");

  a_lock_cause: assert property (@(posedge ref_clk) disable iff (!rstn)
    $rose(st.locked) |-> $past(pre_evt))
    else $error("lock changed outside a compare window");

  a_step_up: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && step_evt && st.step_s3[3] && st.step_s3[2:0] == 3'h7) |=> (st.m_tap == $past(st.m_tap) + 3'h1))
    else $error("feedback tap did not advance on a phase step");

  a_ready_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && st.pready) |=> !st.pready)
    else $error("pready held for more than one cycle");

  // helper for the prescale check: same edge qualification as the logic
  function automatic logic in_rise_chk();
    return (st.in_s2[0] == st.in_s3[0]) && st.in_s3[0] && !st.in_lvl[0];
  endfunction

endmodule
`default_nettype wire

// file: common/pll_net_pkg.sv
// constants, field layouts and types shared by the pll counter network
package pll_net_pkg;

  // ******************************************************************
  // register map (byte addresses)
  // ******************************************************************
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] PRESCALE_OFS = 12'h008;
  localparam logic [11:0] FEEDBACK_OFS = 12'h00c;
  localparam logic [11:0] OUT_BASE_OFS = 12'h010;
  localparam int unsigned NUM_OUT = 7;

  // ******************************************************************
  // field positions
  // ******************************************************************
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_EXTFB_BIT = 1;
  localparam int unsigned STAT_LOCK_BIT = 0;
  localparam int unsigned STAT_CASC_LSB = 8;
  localparam int unsigned STAT_INC_LSB = 16;
  localparam int unsigned DIV_LSB = 0;
  localparam int unsigned FB_TAP_LSB = 16;
  localparam int unsigned OUT_HIGH_LSB = 0;
  localparam int unsigned OUT_LOW_LSB = 8;
  localparam int unsigned OUT_INIT_LSB = 16;
  localparam int unsigned OUT_TAP_LSB = 25;
  localparam int unsigned OUT_BYP_BIT = 28;

  // ******************************************************************
  // widths and reset values
  // ******************************************************************
  localparam int unsigned CNT_W = 9;
  localparam int unsigned HALF_W = 8;
  localparam int unsigned ACC_W = 16;
  localparam int unsigned INC_W = 13;
  localparam logic [12:0] INC_RST = 13'h0400;
  localparam logic [12:0] INC_MAX = 13'h1fff;
  localparam logic [8:0] DIV_M1_RST = 9'h000;
  localparam logic [7:0] HALF_M1_RST = 8'h00;
  localparam logic [8:0] INIT_RST = 9'h001;
  localparam logic [2:0] TAP_RST = 3'h0;
  localparam logic [2:0] STEP_SEL_FB = 3'h7;

  // output divider sequencing, gray along delay -> high -> low
  typedef enum logic [1:0] {
    DIV_DELAY = 2'b00,
    DIV_HIGH = 2'b01,
    DIV_LOW = 2'b11
  } div_phase_t;

  // one output divider's settings
  typedef struct packed {
    logic bypass;
    logic [2:0] tap;
    logic [8:0] init_cnt;
    logic [7:0] low_m1;
    logic [7:0] high_m1;
  } out_cfg_t;

endpackage

// file: hdl/out_divider.sv
// one post-scale output divider: start delay, high count, low count
`timescale 1ns/100ps
`default_nettype none
module out_divider (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  // control
  input wire logic hold,
  input wire logic tick,
  input wire logic vco_level,
  input wire logic bypass,
  input wire logic [7:0] high_m1,
  input wire logic [7:0] low_m1,
  input wire logic [8:0] init_cnt,
  // divided clock
  output logic div_out,
  output logic div_rise
);

  typedef struct packed {
    pll_net_pkg::div_phase_t phase;
    logic [8:0] cnt;
    logic out;
    logic rise;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;

  // ******************************************************************
  // sequencing
  // ******************************************************************
  // counts are loaded minus one so that a setting of 1 lasts one tick
  always_comb begin
    next_st = st;
    next_st.rise = 1'b0;
    if (hold) begin
      // an init count of zero is treated as one: no coarse delay
      next_st.phase = pll_net_pkg::DIV_DELAY;
      next_st.cnt = (init_cnt == 9'h000) ? 9'h000 : init_cnt - 9'h001;
      next_st.out = 1'b0;
    end else if (bypass) begin
      next_st.out = vco_level; // divide by one follows the tap itself
      next_st.rise = tick;
    end else if (tick) begin
      if (st.cnt != 9'h000) begin
        next_st.cnt = st.cnt - 9'h001;
      end else begin
        case (st.phase)
          pll_net_pkg::DIV_DELAY, pll_net_pkg::DIV_LOW: begin
            next_st.phase = pll_net_pkg::DIV_HIGH;
            next_st.cnt = {1'b0, high_m1};
            next_st.out = 1'b1;
            next_st.rise = 1'b1;
          end
          pll_net_pkg::DIV_HIGH: begin
            next_st.phase = pll_net_pkg::DIV_LOW; // period is high plus low
            next_st.cnt = {1'b0, low_m1};
            next_st.out = 1'b0;
          end
          default: begin
            next_st.phase = pll_net_pkg::DIV_DELAY;
            next_st.cnt = 9'h000;
            next_st.out = 1'b0;
          end
        endcase
      end
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign div_out = st.out;
  assign div_rise = st.rise;

  // ******************************************************************
  // checks
  // ******************************************************************
  a_delay_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st.phase == pll_net_pkg::DIV_DELAY && !$past(bypass)) |-> !st.out)
    else $error("divider output high during start delay");

  a_high_ends: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ce && tick && !hold && !bypass && st.phase == pll_net_pkg::DIV_HIGH && st.cnt == 9'h000)
    |=> (st.phase == pll_net_pkg::DIV_LOW && !st.out && st.cnt == {1'b0, $past(low_m1)}))
    else $error("high time did not hand over to low time");

  a_rise_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st.rise && !$past(bypass)) |-> st.out)
    else $error("rise pulse without high output");

endmodule
`default_nettype wire

// file: test/pll_cfg_partner.sv
// far-side model: reference source, feedback board trace and phase step controller
`timescale 1ns/100ps
`default_nettype none
module pll_cfg_partner #(
  parameter int REF_HALF = 32,
  parameter int STEP_HOLD = 6
) (
  // clock and bench control
  input wire logic ref_clk,
  input wire logic ref_on,
  // loop pins
  input wire logic feedback_output,
  output logic feedback_in,
  output logic ref_in = 1'b0,
  // phase step pins
  output logic phase_step_clock = 1'b0,
  output logic phase_step_up = 1'b0,
  output logic [2:0] phase_step_sel = 3'h0
);
  int ref_cnt = 0;

  // board trace from the feedback output straight back to the feedback pin
  assign feedback_in = feedback_output;

  // reference source, held still while disabled so the loop is not trimmed
  always @(posedge ref_clk) begin
    if (!ref_on) begin
      ref_cnt <= 0;
      ref_in <= 1'b0;
    end else if (ref_cnt == REF_HALF - 1) begin
      ref_cnt <= 0;
      ref_in <= !ref_in;
    end else begin
      ref_cnt <= ref_cnt + 1;
    end
  end

  // one tap step; select and direction held well clear of the step edge
  task automatic step(input logic [2:0] sel, input logic up);
    @(posedge ref_clk);
    phase_step_sel <= sel;
    phase_step_up <= up;
    repeat (STEP_HOLD) @(posedge ref_clk);
    phase_step_clock <= 1'b1;
    repeat (STEP_HOLD) @(posedge ref_clk);
    phase_step_clock <= 1'b0;
    repeat (STEP_HOLD) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// file: test/pll_counter_divider_phase_network_tb.sv
// self-checking bench for the pll counter network over apb
`timescale 1ns/100ps
`default_nettype none
module pll_counter_divider_phase_network_tb;
  logic ref_clk, rstn, ce, psel, penable, pwrite, ref_on, arm, pready, pslverr, locked;
  logic ref_in, feedback_in, feedback_output, phase_step_clock, phase_step_up;
  logic [2:0] phase_step_sel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, stat_exp;
  logic [6:0] clk_out, prev, seen;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int t_rise[7];
  int hi, lo, n;

  pll_counter_network #(.CASCADE_MASK(7'h40)) i_pll_counter_network (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_in(ref_in), .feedback_in(feedback_in),
    .feedback_output(feedback_output), .phase_step_clock(phase_step_clock), .phase_step_up(phase_step_up),
    .phase_step_sel(phase_step_sel), .clk_out(clk_out), .locked(locked));

  pll_cfg_partner #(.REF_HALF(32), .STEP_HOLD(6)) i_pll_cfg_partner (.ref_clk(ref_clk), .ref_on(ref_on),
    .feedback_output(feedback_output), .feedback_in(feedback_in), .ref_in(ref_in),
    .phase_step_clock(phase_step_clock), .phase_step_up(phase_step_up), .phase_step_sel(phase_step_sel));

  // ******************************************************************
  // clock, first-rise tracker, helpers
  // ******************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // records the first rising edge of each output after arming; sampled
  // between edges so registered outputs are settled
  always @(negedge ref_clk) begin
    cyc <= cyc + 1;
    prev <= clk_out;
    for (int k = 0; k < 7; k++) begin
      if (clk_out[k] && !prev[k] && !seen[k] && !arm) begin
        t_rise[k] <= cyc;
        seen[k] <= 1'b1;
      end
    end
    if (arm) begin
      seen <= 7'h00;
    end
  end

  function automatic logic [31:0] ov(input logic [7:0] h, input logic [7:0] l, input logic [8:0] ini,
                                     input logic [2:0] tp, input logic by);
    return {3'h0, by, tp, ini, l, h};
  endfunction

  function automatic logic [11:0] oa(input int i);
    return pll_net_pkg::OUT_BASE_OFS + 12'(4 * i);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; waits for pready rather than assuming a latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int w;
    w = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // look between edges so the value seen is the one the next edge samples
    do begin
      @(negedge ref_clk);
      w++;
    end while (pready !== 1'b1 && w < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: no pready", $time);
    end
    q = prdata;
    e = pslverr;
    // hold the request through the edge that samples pready high
    @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & msk, exp);
  endtask

  // counts high then low cycles of one output from its next rising edge
  task automatic meas(input int k, output int h, output int l);
    int b;
    b = 0;
    h = 0;
    l = 0;
    while (clk_out[k] !== 1'b0 && b < 40000) begin
      @(negedge ref_clk);
      b++;
    end
    while (clk_out[k] !== 1'b1 && b < 40000) begin
      @(negedge ref_clk);
      b++;
    end
    while (clk_out[k] === 1'b1 && b < 40000) begin
      @(negedge ref_clk);
      h++;
      b++;
    end
    while (clk_out[k] === 1'b0 && b < 40000) begin
      @(negedge ref_clk);
      l++;
      b++;
    end
  endtask

  task automatic finish_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run of about 25k cycles
  initial begin
    #900000;
    fail_count++;
    finish_test();
  end

  // ******************************************************************
  // tests
  // ******************************************************************
  initial begin : main
    logic [31:0] q;
    logic e;
    {rstn, ce, psel, penable, pwrite, ref_on, arm} = 7'h20;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    // vco period stays 64 cycles while the reference is still
    stat_exp = {3'h0, pll_net_pkg::INC_RST, 1'b0, 7'h40, 8'h00};
    rdchk(pll_net_pkg::CTRL_OFS, 32'h0, 32'hffffffff);
    rdchk(pll_net_pkg::STATUS_OFS, stat_exp, 32'hfffffffe);
    for (int i = 0; i < 7; i++) begin
      rdchk(oa(i), ov(8'h00, 8'h00, 9'h001, 3'h0, 1'b0), 32'hffffffff);
    end
    apb(1'b0, 12'h02c, 32'h0, q, e);
    chk({e, q[30:0]}, 32'h80000000);
    // widest counts, no duty field on the prescaler, cascade not writable
    wr(pll_net_pkg::PRESCALE_OFS, 32'hffffffff);
    rdchk(pll_net_pkg::PRESCALE_OFS, 32'h000001ff, 32'hffffffff);
    wr(pll_net_pkg::FEEDBACK_OFS, 32'hffffffff);
    rdchk(pll_net_pkg::FEEDBACK_OFS, 32'h000701ff, 32'hffffffff);
    wr(oa(1), 32'hffffffff);
    rdchk(oa(1), 32'h1fffffff, 32'hffffffff);
    wr(pll_net_pkg::STATUS_OFS, 32'h0);
    rdchk(pll_net_pkg::STATUS_OFS, stat_exp, 32'hfffffffe);
    // each divider i below 6 divides by i+2; output 6 chained behind output 5 divides by 2
    for (int i = 0; i < 6; i++) begin
      wr(oa(i), ov(8'(i), 8'h00, 9'h001, 3'h0, 1'b0));
    end
    wr(oa(6), ov(8'h00, 8'h00, 9'h001, 3'h0, 1'b0));
    wr(pll_net_pkg::CTRL_OFS, 32'h1);
    for (int i = 0; i < 6; i++) begin
      meas(i, hi, lo);
      chk(32'(hi), 32'((i + 1) * 64));
      chk(32'(lo), 32'h40);
    end
    meas(6, hi, lo);
    chk(32'(hi + lo), 32'h380);
    // top of the high count and divide-by-one bypass
    wr(pll_net_pkg::CTRL_OFS, 32'h0);
    wr(oa(4), ov(8'hff, 8'h00, 9'h001, 3'h0, 1'b0));
    wr(oa(0), ov(8'h00, 8'h00, 9'h001, 3'h0, 1'b1));
    wr(pll_net_pkg::CTRL_OFS, 32'h1);
    meas(4, hi, lo);
    chk(32'(hi), 32'h4000);
    meas(0, hi, lo);
    chk(32'(hi + lo), 32'h40);
    // fine and coarse phase offsets between same-rate outputs
    wr(pll_net_pkg::CTRL_OFS, 32'h0);
    wr(oa(0), ov(8'h01, 8'h01, 9'h001, 3'h0, 1'b0));
    wr(oa(1), ov(8'h01, 8'h01, 9'h001, 3'h3, 1'b0));
    wr(oa(2), ov(8'h01, 8'h01, 9'h003, 3'h0, 1'b0));
    arm <= 1'b1;
    @(posedge ref_clk);
    arm <= 1'b0;
    wr(pll_net_pkg::CTRL_OFS, 32'h1);
    n = 0;
    while (seen[2:0] !== 3'h7 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    chk(32'((((t_rise[1] - t_rise[0]) % 64) + 64) % 64), 32'h18);
    chk(32'(t_rise[2] - t_rise[0]), 32'h80);
    // dynamic tap steps wrap going up through all eight taps, step back down, and step the feedback tap
    wr(oa(3), ov(8'h02, 8'h02, 9'h001, 3'h7, 1'b0));
    for (int s = 0; s < 8; s++) begin
      i_pll_cfg_partner.step(3'h3, 1'b1);
      rdchk(oa(3), ov(8'h02, 8'h02, 9'h001, 3'(s), 1'b0), 32'hffffffff);
    end
    i_pll_cfg_partner.step(3'h3, 1'b0);
    rdchk(oa(3), ov(8'h02, 8'h02, 9'h001, 3'h6, 1'b0), 32'hffffffff);
    i_pll_cfg_partner.step(pll_net_pkg::STEP_SEL_FB, 1'b1);
    rdchk(pll_net_pkg::FEEDBACK_OFS, 32'h000001ff, 32'hffffffff);
    // external feedback loop locks to a reference matching the vco
    wr(pll_net_pkg::PRESCALE_OFS, 32'h0);
    wr(pll_net_pkg::FEEDBACK_OFS, 32'h0);
    wr(pll_net_pkg::CTRL_OFS, 32'h3);
    ref_on <= 1'b1;
    n = 0;
    while (locked !== 1'b1 && n < 30000) begin
      @(posedge ref_clk);
      n++;
    end
    chk({31'h0, locked}, 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
